// ---- logic/relay_board_map.svh ----
`ifndef RELAY_BOARD_MAP_SVH
`define RELAY_BOARD_MAP_SVH

// word index on the four lowest address lines
`define BOARD_ID_IDX 4'h0
`define CTRL_STATUS_IDX 4'h1
`define OUT_REG_FIRST_IDX 4'h4
`define OUT_REG_LAST_IDX 4'h7
`define CONTACT_FIRST_IDX 4'h8
`define CONTACT_LAST_IDX 4'hb

// control and status word fields
`define CSR_FAIL_LED_BIT 15
`define CSR_LOWER_EN_BIT 14
`define CSR_UPPER_EN_BIT 13
`define CSR_RESET 3'h0

// address modifier fields
`define AM_PRIV_BIT 2
`define AM_SHORT_SPACE 3'h5
`define AM_STD_SPACE 3'h7
`define AM_DATA_ACCESS 2'h1

// timing
`define CLK_PERIOD_NS 25
`define DTACK_DELAY_NS 150
`define DTACK_DELAY_CYC (((`DTACK_DELAY_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define STEER_SETTLE_NS 50
`define STEER_SETTLE_CYC (((`STEER_SETTLE_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))

`endif

// ---- logic/relay_board_pkg.sv ----
package relay_board_pkg;

typedef enum logic [1:0] {
    ST_IDLE,
    ST_BUSY,
    ST_ACK
} cycle_state_t;

typedef struct packed {
    logic write_n;
    logic ds1_n;
    logic ds0_n;
    logic [3:0] word_idx;
} held_access_t;

endpackage

// ---- logic/coil_bus_if.sv ----
`timescale 1ns/1ps
interface coil_bus_if;
    logic [63:0] drive_data;
    logic [1:0] half_en;
    logic [63:0] set_coil;
    logic [63:0] reset_coil;
    logic [63:0] coil_oe;

    modport ctrl (
        output drive_data,
        output half_en,
        input set_coil,
        input reset_coil,
        input coil_oe
    );

    modport drv (
        input drive_data,
        input half_en,
        output set_coil,
        output reset_coil,
        output coil_oe
    );
endinterface

// ---- logic/board_addr_decoder.sv ----
`timescale 1ns/1ps
`include "relay_board_map.svh"
module board_addr_decoder (
    input wire logic [23:5] addr,
    input wire logic [5:0] am,
    input wire logic as_n,
    input wire logic std_space_jumper,
    input wire logic nonpriv_only_jumper,
    input wire logic any_privilege_jumper,
    input wire logic [23:5] base_jumper,
    output logic board_match
);
    logic [23:5] want;
    logic [23:5] care;
    logic space_ok;
    logic priv_ok;

    // installed jumper pulls the compare to zero, absent one expects one
    assign want = ~base_jumper;
    assign care = std_space_jumper ? {19{1'b1}} : {8'h00, 11'h7ff};

    assign space_ok = (am[1:0] == `AM_DATA_ACCESS) &&
                      (am[5:3] == (std_space_jumper ? `AM_STD_SPACE : `AM_SHORT_SPACE));

    // both jumpers fitted behaves as nonprivileged only
    always_comb begin
        if (nonpriv_only_jumper) begin
            priv_ok = ~am[`AM_PRIV_BIT];
        end else if (any_privilege_jumper) begin
            priv_ok = 1'b1;
        end else begin
            priv_ok = am[`AM_PRIV_BIT];
        end
    end

    assign board_match = ~as_n && space_ok && priv_ok && (((addr ^ want) & care) == 19'h0);
endmodule

// ---- logic/relay_coil_driver.sv ----
`timescale 1ns/1ps
module relay_coil_driver (
    input wire logic ref_clk,
    input wire logic reset,
    coil_bus_if.drv coil
);
    genvar ch;
    generate
        for (ch = 0; ch < 64; ch = ch + 1) begin : g_ch
            // set coil through a buffer, reset coil through an inverter
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    coil.set_coil[ch] <= 1'b0;
                    coil.reset_coil[ch] <= 1'b1;
                    coil.coil_oe[ch] <= 1'b0;
                end else begin
                    coil.set_coil[ch] <= coil.drive_data[ch];
                    coil.reset_coil[ch] <= ~coil.drive_data[ch];
                    coil.coil_oe[ch] <= coil.half_en[ch / 32];
                end
            end
        end
    endgenerate
endmodule

// ---- logic/vme_relay_output_slave.sv ----
`timescale 1ns/1ps
`include "relay_board_map.svh"
// How it works
// - jumper absent: A23-A16 ignored, board lives in short I/O space.
// - jumper fitted: upper eight address lines join the base compare.
// - two jumpers pick nonprivileged, either, or supervisory access via AM2.
// - fitted base jumper needs that address line low, absent needs high.
// - on a match board select rises and latches control and A4-A1.
// - writes store bus data only after a settle delay for steering.
// - reads drive data until both data strobes return high.
// - any register always answers; writes to read-only ones are dropped.
// - output registers read back what was last written.
// - DTACK* goes low 150 ns after the board decides to respond.
// - master lifts strobes after DTACK*; board then rearms board select.
// - identification word at base, fixed upper byte, lower byte undriven.
// - control word at next word, only its top three bits used.
// - control bit 15 low lights the fail indicator, high darkens it.
// - control bit 14 enables coil drivers for channels 1 to 32.
// - control bit 13 enables coil drivers for channels 33 to 64.
// - enabled drivers follow output registers, one activates the relay.
// - disabled drivers float, latching relays keep their state.
// - set coil via buffer, reset coil via inverter, one coil energised.
// - contact registers show real contacts; writes while disabled only store.
module vme_relay_output_slave #(
    parameter logic [7:0] BOARD_ID_CODE = 8'h5a // arbitrary value
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [23:1] vme_addr,
    input wire logic [5:0] vme_am,
    input wire logic vme_as_n,
    input wire logic vme_ds0_n,
    input wire logic vme_ds1_n,
    input wire logic vme_write_n,
    input wire logic [15:0] vme_data_in,
    output logic [15:0] vme_data_out,
    output logic [1:0] vme_data_oe,
    output logic vme_dtack_n_out,
    output logic vme_dtack_n_oe,
    input wire logic std_space_jumper,
    input wire logic nonpriv_only_jumper,
    input wire logic any_privilege_jumper,
    input wire logic [23:5] base_jumper,
    input wire logic [63:0] relay_contact,
    output logic [63:0] set_coil,
    output logic [63:0] reset_coil,
    output logic [63:0] coil_oe,
    output logic fail_led_n,
    output logic board_select_active_high
);
    localparam logic [3:0] DTACK_CYC = 4'(`DTACK_DELAY_CYC);
    localparam logic [3:0] SETTLE_CYC = 4'(`STEER_SETTLE_CYC);

    // every pin is asynchronous to ref_clk: two flops before any logic
    localparam int SYNC_W = 23 + 6 + 4 + 16 + 3 + 19 + 64;
    logic [SYNC_W-1:0] pin_meta_ff;
    logic [SYNC_W-1:0] pin_sync_ff;

    logic [23:1] addr_s;
    logic [5:0] am_s;
    logic as_n_s;
    logic ds0_n_s;
    logic ds1_n_s;
    logic write_n_s;
    logic [15:0] data_s;
    logic std_s;
    logic nonpriv_s;
    logic anypriv_s;
    logic [23:5] base_s;
    logic [63:0] contact_s;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            // both stages preset idle so no strobe or address strobe is seen low after reset
            pin_meta_ff <= '1;
            pin_sync_ff <= '1;
        end else begin
            pin_meta_ff <= {vme_addr, vme_am, vme_as_n, vme_ds0_n, vme_ds1_n, vme_write_n, vme_data_in,
                            std_space_jumper, nonpriv_only_jumper, any_privilege_jumper, base_jumper,
                            relay_contact};
            pin_sync_ff <= pin_meta_ff;
        end
    end

    assign {addr_s, am_s, as_n_s, ds0_n_s, ds1_n_s, write_n_s, data_s,
            std_s, nonpriv_s, anypriv_s, base_s, contact_s} = pin_sync_ff;

    // byte lanes: ds1 carries the upper byte, ds0 the lower
    function automatic logic [15:0] lane_merge(input logic [15:0] old_val, input logic [15:0] new_val,
                                               input logic ds1_n, input logic ds0_n);
        lane_merge = {ds1_n ? old_val[15:8] : new_val[15:8], ds0_n ? old_val[7:0] : new_val[7:0]};
    endfunction

    function automatic logic in_range(input logic [3:0] idx, input logic [3:0] lo, input logic [3:0] hi);
        in_range = (idx >= lo) && (idx <= hi);
    endfunction

    logic board_match;
    logic strobe_seen;
    logic strobes_high;

    board_addr_decoder u_decoder (
        .addr(addr_s[23:5]),
        .am(am_s),
        .as_n(as_n_s),
        .std_space_jumper(std_s),
        .nonpriv_only_jumper(nonpriv_s),
        .any_privilege_jumper(anypriv_s),
        .base_jumper(base_s),
        .board_match(board_match)
    );

    assign strobe_seen = ~ds0_n_s | ~ds1_n_s;
    assign strobes_high = ds0_n_s & ds1_n_s;

    relay_board_pkg::cycle_state_t state_ff;
    relay_board_pkg::cycle_state_t nxt_state;
    relay_board_pkg::held_access_t held_ff;
    logic [3:0] count_ff;
    logic board_select_ff;
    logic dtack_ff;
    logic store_now;
    logic read_now;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            relay_board_pkg::ST_IDLE: begin
                if (board_match && strobe_seen) begin
                    nxt_state = relay_board_pkg::ST_BUSY;
                end
            end
            relay_board_pkg::ST_BUSY: begin
                if (count_ff == DTACK_CYC - 4'h1) begin
                    nxt_state = relay_board_pkg::ST_ACK;
                end
            end
            relay_board_pkg::ST_ACK: begin
                if (strobes_high) begin
                    nxt_state = relay_board_pkg::ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_ff <= relay_board_pkg::ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // the held copy lets the master move on while this cycle finishes
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            held_ff <= '0;
        end else if (state_ff == relay_board_pkg::ST_IDLE && nxt_state == relay_board_pkg::ST_BUSY) begin
            held_ff <= '{write_n: write_n_s, ds1_n: ds1_n_s, ds0_n: ds0_n_s, word_idx: addr_s[4:1]};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            board_select_ff <= 1'b0;
        end else if (state_ff == relay_board_pkg::ST_IDLE) begin
            board_select_ff <= nxt_state == relay_board_pkg::ST_BUSY;
        end else if (state_ff == relay_board_pkg::ST_ACK && strobes_high) begin
            board_select_ff <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            count_ff <= 4'h0;
        end else if (state_ff == relay_board_pkg::ST_BUSY) begin
            count_ff <= count_ff + 4'h1;
        end else begin
            count_ff <= 4'h0;
        end
    end

    // dtack counted from the decision edge, held until strobes rise
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            dtack_ff <= 1'b0;
        end else if (state_ff == relay_board_pkg::ST_BUSY && count_ff == DTACK_CYC - 4'h1) begin
            dtack_ff <= 1'b1;
        end else if (state_ff == relay_board_pkg::ST_ACK && strobes_high) begin
            dtack_ff <= 1'b0;
        end
    end

    // data is taken only after the steering settle time, well before dtack
    assign store_now = state_ff == relay_board_pkg::ST_BUSY && count_ff == SETTLE_CYC && ~held_ff.write_n;
    assign read_now = state_ff == relay_board_pkg::ST_BUSY && count_ff == 4'h0 && held_ff.write_n;

    logic [2:0] csr_ff;
    logic [15:0] csr_merged;
    logic [15:0] out_reg_ff [0:3];

    assign csr_merged = lane_merge({csr_ff, 13'h0000}, data_s, held_ff.ds1_n, held_ff.ds0_n);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            csr_ff <= `CSR_RESET;
        end else if (store_now && held_ff.word_idx == `CTRL_STATUS_IDX) begin
            // only the top three bits exist; lower bits vanish
            csr_ff <= csr_merged[15:13];
        end
    end

    genvar w;
    generate
        for (w = 0; w < 4; w = w + 1) begin : g_out
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    out_reg_ff[w] <= 16'h0000;
                end else if (store_now && held_ff.word_idx == `OUT_REG_FIRST_IDX + 4'(w)) begin
                    out_reg_ff[w] <= lane_merge(out_reg_ff[w], data_s, held_ff.ds1_n, held_ff.ds0_n);
                end
            end
        end
    endgenerate

    // writes to id, contact and unused words fall through here and are lost
    logic [15:0] read_word;
    logic [1:0] read_lanes;
    logic [1:0] ctr_off;

    always_comb begin
        read_word = 16'h0000;
        read_lanes = {~held_ff.ds1_n, ~held_ff.ds0_n};
        ctr_off = held_ff.word_idx[1:0];
        if (held_ff.word_idx == `BOARD_ID_IDX) begin
            read_word = {BOARD_ID_CODE, 8'h00};
            read_lanes[0] = 1'b0;
        end else if (held_ff.word_idx == `CTRL_STATUS_IDX) begin
            read_word = {csr_ff, 13'h0000};
        end else if (in_range(held_ff.word_idx, `OUT_REG_FIRST_IDX, `OUT_REG_LAST_IDX)) begin
            read_word = out_reg_ff[ctr_off];
        end else if (in_range(held_ff.word_idx, `CONTACT_FIRST_IDX, `CONTACT_LAST_IDX)) begin
            read_word = contact_s[16*ctr_off +: 16];
        end
    end

    logic [15:0] data_out_ff;
    logic [1:0] data_oe_ff;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            data_out_ff <= 16'h0000;
            data_oe_ff <= 2'h0;
        end else if (read_now) begin
            data_out_ff <= read_word;
            data_oe_ff <= read_lanes;
        end else if (state_ff == relay_board_pkg::ST_ACK && strobes_high) begin
            data_oe_ff <= 2'h0;
        end
    end

    coil_bus_if coil ();

    assign coil.drive_data = {out_reg_ff[3], out_reg_ff[2], out_reg_ff[1], out_reg_ff[0]};
    assign coil.half_en = {csr_ff[`CSR_UPPER_EN_BIT - 13], csr_ff[`CSR_LOWER_EN_BIT - 13]};

    relay_coil_driver u_coils (
        .ref_clk(ref_clk),
        .reset(reset),
        .coil(coil.drv)
    );

    assign set_coil = coil.set_coil;
    assign reset_coil = coil.reset_coil;
    assign coil_oe = coil.coil_oe;

    assign vme_data_out = data_out_ff;
    assign vme_data_oe = data_oe_ff;
    // open drain: the pin level is only ever pulled low
    assign vme_dtack_n_out = 1'b0;
    assign vme_dtack_n_oe = dtack_ff;
    assign fail_led_n = csr_ff[`CSR_FAIL_LED_BIT - 13];
    assign board_select_active_high = board_select_ff;
endmodule

// ---- verification/vme_relay_output_slave_properties.sv ----
`timescale 1ns/1ps
module relay_slave_props #(
    parameter logic [7:0] BOARD_ID_CODE = 8'h5a
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [23:1] vme_addr,
    input wire logic vme_ds0_n,
    input wire logic vme_ds1_n,
    input wire logic vme_write_n,
    input wire logic [15:0] vme_data_out,
    input wire logic [1:0] vme_data_oe,
    input wire logic vme_dtack_n_oe,
    input wire logic [63:0] set_coil,
    input wire logic [63:0] reset_coil,
    input wire logic [63:0] coil_oe,
    input wire logic fail_led_n,
    input wire logic board_select_active_high
);
    logic up;
    assign up = vme_ds0_n && vme_ds1_n;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    a_dtack_delay: assert property ($rose(board_select_active_high) |->
        !vme_dtack_n_oe [*5] ##[1:2] $rose(vme_dtack_n_oe)) else $error("dtack delay wrong");
    a_dtack_holds: assert property (vme_dtack_n_oe && !up |=> vme_dtack_n_oe)
        else $error("dtack dropped while strobes low");
    a_strobe_rearm: assert property (up [*4] |-> !board_select_active_high && !vme_dtack_n_oe)
        else $error("board select not rearmed");
    a_read_hold: assert property ($fell(|vme_data_oe) |-> $past(up, 2))
        else $error("read data released early");
    a_write_quiet: assert property (board_select_active_high && !vme_write_n |-> vme_data_oe == 2'b00)
        else $error("data driven in write");
    a_id_word: assert property ($rose(|vme_data_oe) && vme_addr[4:1] == 4'h0 |->
        vme_data_oe == 2'b10 && vme_data_out[15:8] == BOARD_ID_CODE) else $error("id word wrong");
    a_coil_pair: assert property (set_coil == ~reset_coil)
        else $error("both coils driven alike");
    a_half_enables: assert property (coil_oe[31:0] == {32{coil_oe[0]}} &&
        coil_oe[63:32] == {32{coil_oe[32]}}) else $error("half enable split");
    a_led_in_cycle: assert property ($changed(fail_led_n) |-> board_select_active_high)
        else $error("led changed outside a cycle");
    a_oe_after_write: assert property ($changed(coil_oe) |-> $past(board_select_active_high))
        else $error("coil enable changed outside a cycle");
endmodule
bind vme_relay_output_slave relay_slave_props #(.BOARD_ID_CODE(BOARD_ID_CODE)) u_props (.ref_clk, .reset,
    .vme_addr, .vme_ds0_n, .vme_ds1_n, .vme_write_n, .vme_data_out, .vme_data_oe, .vme_dtack_n_oe,
    .set_coil, .reset_coil, .coil_oe, .fail_led_n, .board_select_active_high);

// ---- verification/vme_host_model.sv ----
`timescale 1ns/1ps
module vme_host_model (
    input wire logic ref_clk,
    output logic [23:1] vme_addr,
    output logic [5:0] vme_am,
    output logic vme_as_n,
    output logic vme_ds0_n,
    output logic vme_ds1_n,
    output logic vme_write_n,
    output logic [15:0] vme_data_in,
    input wire logic [15:0] vme_data_out,
    input wire logic vme_dtack_n_oe
);
    initial begin
        vme_addr = 23'h0;
        vme_am = 6'h0;
        {vme_as_n, vme_ds1_n, vme_ds0_n, vme_write_n} = 4'hf;
        vme_data_in = 16'h0;
    end
    // dsn is {ds1_n, ds0_n}; acked stays low when nobody answers within the bound
    task automatic cycle(input logic wr, input logic [23:1] a, input logic [5:0] m, input logic [1:0] dsn,
                         input logic [15:0] wd, output logic [15:0] rd, output logic acked);
        int n;
        @(negedge ref_clk);
        vme_addr = a;
        vme_am = m;
        vme_write_n = !wr;
        vme_data_in = wd;
        vme_as_n = 1'b0;
        {vme_ds1_n, vme_ds0_n} = dsn;
        n = 0;
        // look just after the edge so the acknowledge launched there has settled
        do begin
            @(posedge ref_clk);
            #1;
        end while (vme_dtack_n_oe !== 1'b1 && n++ < 24);
        acked = (vme_dtack_n_oe === 1'b1);
        rd = vme_data_out;
        @(negedge ref_clk);
        vme_as_n = 1'b1;
        {vme_ds1_n, vme_ds0_n} = 2'b11;
        // released lines must not keep showing the old value
        vme_data_in = ~wd;
        vme_addr = ~a;
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
        end while (vme_dtack_n_oe !== 1'b0 && n++ < 8);
        repeat (2) @(posedge ref_clk);
    endtask
endmodule

// ---- verification/test_vme_relay_output_slave.sv ----
`timescale 1ns/1ps
`define chk(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module test_vme_relay_output_slave;
    localparam logic [23:0] BASE = 24'h3a_a5c0;
    localparam logic [7:0] ID = 8'hc3; // arbitrary value
    localparam logic [5:0] AM = 6'h2d;
    localparam logic [63:0] PAT = 64'h0f0f_fedc_1234_8001;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [23:1] vme_addr;
    logic [5:0] vme_am;
    logic vme_as_n, vme_ds0_n, vme_ds1_n, vme_write_n, vme_dtack_n_out, vme_dtack_n_oe;
    logic [15:0] vme_data_in, vme_data_out;
    logic [1:0] vme_data_oe;
    logic std_space_jumper, nonpriv_only_jumper, any_privilege_jumper, fail_led_n, board_select_active_high;
    logic [23:5] base_jumper;
    logic [63:0] relay_contact, set_coil, reset_coil, coil_oe;
    int n_fail = 0;
    int check_count = 0;
    int cyc = 0;
    vme_relay_output_slave #(.BOARD_ID_CODE(ID)) dut (.ref_clk, .reset, .vme_addr, .vme_am, .vme_as_n,
        .vme_ds0_n, .vme_ds1_n, .vme_write_n, .vme_data_in, .vme_data_out, .vme_data_oe, .vme_dtack_n_out,
        .vme_dtack_n_oe, .std_space_jumper, .nonpriv_only_jumper, .any_privilege_jumper, .base_jumper,
        .relay_contact, .set_coil, .reset_coil, .coil_oe, .fail_led_n, .board_select_active_high);
    vme_host_model host (.ref_clk, .vme_addr, .vme_am, .vme_as_n, .vme_ds0_n, .vme_ds1_n, .vme_write_n,
        .vme_data_in, .vme_data_out, .vme_dtack_n_oe);
    always #12.5 ref_clk = ~ref_clk;
    // relays latch at once; the real pull-in time is left out to keep the run short
    always @(negedge ref_clk) begin
        if (reset) begin
            relay_contact <= 64'h0;
        end else begin
            relay_contact <= (set_coil & coil_oe) | (relay_contact & ~coil_oe);
        end
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            close_out();
        end
    end
    task automatic close_out();
        if (n_fail == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic acc(input logic wr, input logic [3:0] idx, input logic [15:0] wd, output logic [15:0] d);
        logic ok;
        host.cycle(wr, {BASE[23:5], idx}, AM, 2'b00, wd, d, ok);
        `chk("ack", 1'b1, ok)
    endtask
    task automatic t_reset();
        logic [15:0] d;
        `chk("led rst", 1'b0, fail_led_n)
        `chk("oe rst", 64'h0, coil_oe)
        acc(1'b0, 4'h1, 16'h0, d);
        `chk("csr rst", 3'h0, d[15:13])
    endtask
    task automatic t_csr();
        logic [15:0] d;
        logic [2:0] p;
        acc(1'b1, 4'h0, 16'h0000, d);
        acc(1'b0, 4'h0, 16'h0000, d);
        `chk("id", ID, d[15:8])
        for (int i = 0; i < 4; i++) begin
            p = 3'b100 >> i;
            acc(1'b1, 4'h1, {p, 13'h1fff}, d);
            acc(1'b0, 4'h1, 16'h0, d);
            `chk("csr", p, d[15:13])
            `chk("led", p[2], fail_led_n)
            `chk("coil oe", {{32{p[0]}}, {32{p[1]}}}, coil_oe)
        end
    endtask
    task automatic t_outputs();
        logic [15:0] d;
        for (int i = 0; i < 4; i++) begin
            acc(1'b0, 4'h8 + 4'(i), 16'h0, d);
            acc(1'b1, 4'h4 + 4'(i), d, d);
        end
        acc(1'b1, 4'h1, 16'he000, d);
        for (int i = 0; i < 4; i++) begin
            acc(1'b1, 4'h4 + 4'(i), PAT[16*i +: 16], d);
            acc(1'b0, 4'h4 + 4'(i), 16'h0, d);
            `chk("out", PAT[16*i +: 16], d)
        end
        `chk("set", PAT, set_coil)
        `chk("reset coil", ~PAT, reset_coil)
        acc(1'b1, 4'h1, 16'h8000, d);
        acc(1'b1, 4'h8, 16'hdead, d);
        for (int i = 0; i < 4; i++) begin
            acc(1'b1, 4'h4 + 4'(i), ~PAT[16*i +: 16], d);
            acc(1'b0, 4'h8 + 4'(i), 16'h0, d);
            `chk("contact", PAT[16*i +: 16], d)
        end
        `chk("oe off", 64'h0, coil_oe)
        acc(1'b0, 4'h4, 16'h0, d);
        `chk("out off", ~PAT[15:0], d)
    endtask
    task automatic t_lanes();
        logic [15:0] d;
        logic ok;
        host.cycle(1'b1, {BASE[23:5], 4'h5}, AM, 2'b01, 16'h55aa, d, ok);
        `chk("ack lane", 1'b1, ok)
        acc(1'b0, 4'h5, 16'h0, d);
        `chk("lane", {8'h55, ~PAT[23:16]}, d)
    endtask
    task automatic try(input logic [18:0] hi, input logic [5:0] m, input logic exp);
        logic [15:0] d;
        logic ok;
        host.cycle(1'b0, {hi, 4'h0}, m, 2'b00, 16'h0, d, ok);
        `chk("claim", exp, ok)
    endtask
    task automatic t_decode();
        for (int k = 0; k < 4; k++) begin
            @(negedge ref_clk);
            {nonpriv_only_jumper, any_privilege_jumper} = 2'(k);
            try(BASE[23:5], 6'h29, k != 0);
            try(BASE[23:5], 6'h2d, k < 2);
        end
        @(negedge ref_clk);
        {nonpriv_only_jumper, any_privilege_jumper} = 2'b01;
        try({~BASE[23:16], BASE[15:5]}, AM, 1'b1);
        try(BASE[23:5] ^ 19'h1, AM, 1'b0);
        try(BASE[23:5] ^ 19'h400, AM, 1'b0);
        @(negedge ref_clk);
        std_space_jumper = 1'b1;
        try({~BASE[23:16], BASE[15:5]}, 6'h3d, 1'b0);
        try(BASE[23:5], 6'h3d, 1'b1);
    endtask
    initial begin
        std_space_jumper = 1'b0;
        nonpriv_only_jumper = 1'b0;
        any_privilege_jumper = 1'b1;
        base_jumper = ~BASE[23:5];
        repeat (10) @(negedge ref_clk);
        reset = 1'b0;
        repeat (4) @(negedge ref_clk);
        t_reset();
        t_csr();
        t_outputs();
        t_lanes();
        t_decode();
        close_out();
    end
endmodule
